// ==== core/mlpa_matrix.sv ====
`timescale 1ns/1ps
// Function
// - Separate slaves are served in parallel
// - Each master has fixed natural priority
// - Contending masters: highest priority granted first
// - Lower masters stall during higher transaction
// - Paused higher master lends slave to lower
// - Higher request preempts lower after word
// - Same-level masters never active together
// - Fixed ranking CPU down to quad flash, then two spares
// - Unsafe-stall masters may lose data stalled
// ============================================================
// Multilayer interconnect arbitration matrix
module mlpa_matrix
  import mlpa_pkg::*;
#(
  parameter int N_SLV = mlpa_pkg::N_SLAVES,
  parameter int SW    = (N_SLV > 1) ? $clog2(N_SLV) : 1
)(
  input  logic                                    i_clock,
  input  logic                                    i_srst,
  input  logic [mlpa_pkg::N_MASTERS-1:0]          i_req,
  input  logic [mlpa_pkg::N_MASTERS-1:0][SW-1:0]  i_sel,
  input  logic [N_SLV-1:0]                        i_word_done,
  output logic [mlpa_pkg::N_MASTERS-1:0]          o_grant,
  output logic [mlpa_pkg::N_MASTERS-1:0]          o_stall,
  output logic [N_SLV-1:0][mlpa_pkg::MW-1:0]      o_owner,
  output logic [N_SLV-1:0]                        o_busy,
  output logic [mlpa_pkg::N_MASTERS-1:0]          o_unsafe_loss
);
  import mlpa_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (N_SLV < 1) begin : g_bad_slaves
    $error("at least one slave port needed");
  end
  if (SW < $clog2(N_SLV) || (2 ** MW) < N_MASTERS) begin : g_bad_width
    $error("index widths too small");
  end

  // ==========================================================
  // Signals
  logic [N_SLV-1:0][N_MASTERS-1:0] slv_grant;  // Grants per slave
  logic [N_SLV-1:0][MW-1:0]        slv_owner;  // Owners per slave
  logic [N_SLV-1:0]                slv_busy;   // Busy per slave
  logic [N_MASTERS-1:0]            loss_reg;   // Stalled unsafe master
  logic [N_MASTERS-1:0]            loss_next;

  // ==========================================================
  // One arbiter per slave port, independent paths
  for (genvar s = 0; s < N_SLV; s++) begin : g_slave
    mlpa_arb_if #(.N(N_MASTERS), .W(MW)) link ();

    // Route requests addressed to this slave
    always_comb begin
      for (int m = 0; m < N_MASTERS; m++) begin
        link.req[m] = i_req[m] && (i_sel[m] == SW'(s));
      end
    end
    assign link.word_done = i_word_done[s];

    // Fixed ranking lives in the arbiter
    mlpa_slave_arb #(
      .N (N_MASTERS),
      .W (MW)
    ) u_arb (
      .i_clock (i_clock),
      .i_srst  (i_srst),
      .bus     (link.arb)
    );

    assign slv_grant[s] = link.grant;
    assign slv_owner[s] = link.owner;
    assign slv_busy[s]  = link.busy;
  end

  // ==========================================================
  // Merge grants toward masters
  always_comb begin
    o_grant = '0;
    for (int s = 0; s < N_SLV; s++) begin
      o_grant = o_grant | slv_grant[s];
    end
  end

  // Requesting but not granted means stalled
  assign o_stall = i_req & ~o_grant;

  assign o_owner = slv_owner;
  assign o_busy  = slv_busy;

  // ==========================================================
  // Loss warning for masters without safe stall
  always_comb begin
    loss_next = o_stall & UNSAFE_STALL_MASK;
  end

  // Register loss warning
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      loss_reg <= '0;
    end else begin
      loss_reg <= loss_next;
    end
  end

  assign o_unsafe_loss = loss_reg;

  // ==========================================================
  // Checks per master
  for (genvar m = 0; m < N_MASTERS; m++) begin : g_chk
    a_grant_has_req: assert property (@(posedge i_clock) disable iff (i_srst)
      o_grant[m] |-> i_req[m] && !o_stall[m])
      else $error("grant without request");

    a_owner_match: assert property (@(posedge i_clock) disable iff (i_srst)
      o_grant[m] |-> o_owner[i_sel[m]] == MW'(m)
        && o_busy[i_sel[m]])
      else $error("granted master is not slave owner");

    a_loss_flag: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_req[m] && !o_grant[m] && UNSAFE_STALL_MASK[m])
        |=> o_unsafe_loss[m])
      else $error("unsafe master stall not flagged");

    a_loss_drops: assert property (@(posedge i_clock) disable iff (i_srst)
      !o_stall[m] |=> !o_unsafe_loss[m])
      else $error("loss warning without a stall");
  end

  // Top master alone on an idle slave is served next cycle
  a_cpu_first: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_req[PRIO_CPU] && !o_busy[i_sel[PRIO_CPU]])
      ##1 (i_req[PRIO_CPU] && $stable(i_sel))
      |-> o_grant[PRIO_CPU])
    else $error("top master not granted idle slave");

  // ==========================================================
  // Reset leaves every slave free and every grant and loss flag low
  a_rst_all_free: assert property (@(posedge i_clock)
    i_srst |=> o_busy == '0 && o_grant == '0)
    else $error("slave still owned after reset");

  a_rst_no_loss: assert property (@(posedge i_clock)
    i_srst |=> o_unsafe_loss == '0)
    else $error("loss warning set after reset");

  // ==========================================================
  // Checks per slave port
  // They watch the pins only, so a slip in request routing
  // or in grant merging shows up here as well
  for (genvar s = 0; s < N_SLV; s++) begin : g_slv_chk
    logic [N_MASTERS-1:0] to_slv;   // Masters asking this slave
    logic [N_MASTERS-1:0] got_slv;  // Masters granted this slave
    logic [MW-1:0]        top_slv;  // Best ranked asker of this slave
    logic                 own_req;  // Owner still asking this slave

    // Sort requests and grants by selected slave
    always_comb begin
      to_slv  = '0;
      got_slv = '0;
      for (int m = 0; m < N_MASTERS; m++) begin
        to_slv[m]  = i_req[m] && (i_sel[m] == SW'(s));
        got_slv[m] = o_grant[m] && (i_sel[m] == SW'(s));
      end
    end

    // Scan from the bottom so the best rank is written last
    always_comb begin
      top_slv = OWNER_RESET;
      for (int m = N_MASTERS - 1; m >= 0; m--) begin
        if (to_slv[m]) begin
          top_slv = MW'(m);
        end
      end
    end

    assign own_req = to_slv[o_owner[s]];

    // At most one master on this slave at a time
    a_slv_one_grant: assert property (@(posedge i_clock)
      disable iff (i_srst)
      $onehot0(got_slv))
      else $error("two masters granted one slave port");

    // A free slave goes to its best ranked asker
    a_slv_idle_rank: assert property (@(posedge i_clock)
      disable iff (i_srst)
      (!o_busy[s] && (|to_slv))
        |=> o_busy[s] && o_owner[s] == $past(top_slv))
      else $error("free slave not given to best asker");

    // Owner keeps the slave inside a word
    a_slv_keep_word: assert property (@(posedge i_clock)
      disable iff (i_srst)
      (o_busy[s] && own_req && !i_word_done[s])
        |=> $stable(o_owner[s]))
      else $error("slave taken inside a word");

    // Better asker takes over at a word boundary
    a_slv_preempt: assert property (@(posedge i_clock)
      disable iff (i_srst)
      (o_busy[s] && own_req && i_word_done[s] && top_slv < o_owner[s])
        |=> o_owner[s] == $past(top_slv))
      else $error("better asker not served after word");

    // Paused owner lends the slave to the queue
    a_slv_lend: assert property (@(posedge i_clock)
      disable iff (i_srst)
      (o_busy[s] && !own_req && (|to_slv))
        |=> o_busy[s] && o_owner[s] == $past(top_slv))
      else $error("paused owner kept the slave");

    // Nobody asking frees the slave
    a_slv_release: assert property (@(posedge i_clock)
      disable iff (i_srst)
      (o_busy[s] && !(|to_slv)) |=> !o_busy[s])
      else $error("slave kept with no asker");
  end

endmodule : mlpa_matrix

// ==== pkg/mlpa_pkg.sv ====
// ============================================================
// Shared constants of the multilayer priority arbiter
package mlpa_pkg;

  // Number of priority levels, one master port per level
  localparam int N_MASTERS   = 20;
  // Width of a master index
  localparam int MW          = 5;
  // Default number of slave ports
  localparam int N_SLAVES    = 4;

  // Natural priority: lower index wins
  localparam logic [MW-1:0] PRIO_CPU                   = 5'h00;
  localparam logic [MW-1:0] PRIO_NETWORK_CORE          = 5'h01;
  localparam logic [MW-1:0] PRIO_AUDIO_SERIAL          = 5'h02;
  localparam logic [MW-1:0] PRIO_PULSE_DENSITY_MICROPHONE_MASTER = 5'h03;
  localparam logic [MW-1:0] PRIO_SERIAL_GROUP0_MASTER  = 5'h04;
  localparam logic [MW-1:0] PRIO_SERIAL_GROUP1_MASTER  = 5'h05;
  localparam logic [MW-1:0] PRIO_SERIAL_GROUP2_MASTER  = 5'h06;
  localparam logic [MW-1:0] PRIO_SERIAL_GROUP3_MASTER  = 5'h07;
  localparam logic [MW-1:0] PRIO_ANALOG_SAMPLER_MASTER = 5'h08;
  localparam logic [MW-1:0] PRIO_PULSE_WIDTH_UNIT0_MASTER = 5'h09;
  localparam logic [MW-1:0] PRIO_PULSE_WIDTH_UNIT1_MASTER = 5'h0A;
  localparam logic [MW-1:0] PRIO_PULSE_WIDTH_UNIT2_MASTER = 5'h0B;
  localparam logic [MW-1:0] PRIO_PULSE_WIDTH_UNIT3_MASTER = 5'h0C;
  localparam logic [MW-1:0] PRIO_FIFTH_SERIAL_MASTER  = 5'h0D;
  localparam logic [MW-1:0] PRIO_NEAR_FIELD_TAG_MASTER = 5'h0E;
  localparam logic [MW-1:0] PRIO_CRYPTO                = 5'h0F;
  localparam logic [MW-1:0] PRIO_USB_DEVICE_MASTER     = 5'h10;
  localparam logic [MW-1:0] PRIO_QUAD_SERIAL_FLASH     = 5'h11;
  localparam logic [MW-1:0] PRIO_SPARE0                = 5'h12;
  localparam logic [MW-1:0] PRIO_SPARE1                = 5'h13;

  // Masters that cannot stall safely (audio serial, microphone)
  localparam logic [N_MASTERS-1:0] UNSAFE_STALL_MASK = 20'h0000C;

  // Reset value of a slave owner
  localparam logic [MW-1:0] OWNER_RESET = 5'h00;

  // Per-slave arbiter states
  typedef enum logic [0:0] {
    MLPA_IDLE,
    MLPA_OWNED
  } mlpa_state_t;

endpackage : mlpa_pkg

// ==== pkg/mlpa_arb_if.sv ====
`timescale 1ns/1ps
// ============================================================
// Link between the matrix and one slave-port arbiter
interface mlpa_arb_if #(
  parameter int N = 20,
  parameter int W = 5
);
  logic [N-1:0] req;        // Masters requesting this slave
  logic         word_done;  // Current word access completes
  logic [N-1:0] grant;      // One-hot grant
  logic [W-1:0] owner;      // Registered owning master
  logic         busy;       // Slave owned

  // Arbiter side
  modport arb  (input req, word_done, output grant, owner, busy);
  // Matrix side
  modport port (output req, word_done, input grant, owner, busy);
endinterface : mlpa_arb_if

// ==== core/mlpa_slave_arb.sv ====
`timescale 1ns/1ps
// ============================================================
// Fixed-priority arbiter for one slave port
module mlpa_slave_arb
  import mlpa_pkg::*;
#(
  parameter int N = mlpa_pkg::N_MASTERS,
  parameter int W = mlpa_pkg::MW
)(
  input  logic   i_clock,
  input  logic   i_srst,
  mlpa_arb_if.arb bus
);
  import mlpa_pkg::*;

  // ==========================================================
  // State
  mlpa_state_t    state_reg;   // Idle or owned
  mlpa_state_t    state_next;
  logic [W-1:0]   owner_reg;   // Current owner
  logic [W-1:0]   owner_next;
  logic [W-1:0]   hi;          // Highest-priority requester
  logic           any_req;     // Some master requests
  logic           owner_req;   // Owner still requesting

  // ==========================================================
  // Priority encoder, lowest index wins
  always_comb begin
    hi = OWNER_RESET;
    for (int m = N - 1; m >= 0; m--) begin
      if (bus.req[m]) begin
        hi = W'(m);
      end
    end
  end

  assign any_req   = |bus.req;
  assign owner_req = bus.req[owner_reg];

  // ==========================================================
  // Next owner
  always_comb begin
    state_next = state_reg;
    owner_next = owner_reg;
    case (state_reg)
      MLPA_IDLE: begin
        // Grant top requester first
        if (any_req) begin
          state_next = MLPA_OWNED;
          owner_next = hi;
        end
      end
      MLPA_OWNED: begin
        if (!owner_req) begin
          // Owner paused or done: hand to queued master
          if (any_req) begin
            owner_next = hi;
          end else begin
            state_next = MLPA_IDLE;
          end
        end else if (hi < owner_reg && bus.word_done) begin
          // Higher master preempts at word boundary
          owner_next = hi;
        end
        // Otherwise lower masters wait
      end
      default: begin
        state_next = MLPA_IDLE;
        owner_next = OWNER_RESET;
      end
    endcase
  end

  // Register state each cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= MLPA_IDLE;
      owner_reg <= OWNER_RESET;
    end else begin
      state_reg <= state_next;
      owner_reg <= owner_next;
    end
  end

  // ==========================================================
  // Grant decode, one master only
  always_comb begin
    bus.grant = '0;
    if (state_reg == MLPA_OWNED) begin
      bus.grant[owner_reg] = owner_req;
    end
  end

  assign bus.owner = owner_reg;
  assign bus.busy  = (state_reg == MLPA_OWNED);

  // ==========================================================
  // Checks
  a_grant_onehot: assert property (@(posedge i_clock) disable iff (i_srst)
    $onehot0(bus.grant))
    else $error("two masters granted one slave");

  a_top_wins: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_reg == MLPA_IDLE && any_req) |=> owner_reg == $past(hi))
    else $error("idle slave not given to top requester");

  a_hold_till_word: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_reg == MLPA_OWNED && owner_req && !bus.word_done)
      |=> $stable(owner_reg))
    else $error("owner changed inside a word");

  a_preempt_word: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_reg == MLPA_OWNED && owner_req && bus.word_done && hi < owner_reg)
      |=> owner_reg == $past(hi) ##0 bus.busy)
    else $error("higher master not served after word");

  a_pause_handover: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_reg == MLPA_OWNED && !owner_req && any_req)
      |=> owner_reg == $past(hi))
    else $error("paused owner did not hand over");

  a_lower_waits: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_reg == MLPA_OWNED && owner_req && hi == owner_reg)
      |=> owner_reg == $past(owner_reg))
    else $error("lower master took slave from active owner");

  a_idle_release: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_reg == MLPA_OWNED && !any_req) |=> !bus.busy ##1 1'b1)
    else $error("slave not released when no requests");

endmodule : mlpa_slave_arb

// ==== bench/mlpa_master_model.sv ====
`timescale 1ns/1ps
// ============================================================
// Behavioural bus master: requests for i_len granted cycles
module mlpa_master_model (
  input  wire logic       i_clock,
  input  wire logic       i_srst,
  input  wire logic       i_go,    // Start a transaction
  input  wire logic       i_pause, // Pause request mid-transaction
  input  wire logic       i_grant,
  input  wire logic [3:0] i_len,   // Granted cycles wanted
  output logic            o_req
);
  logic [3:0] left_reg;
  logic       act_reg;
  // Keeps requesting while stalled, ends after its words
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      act_reg  <= 1'b0;
      left_reg <= 4'h0;
    end else if (i_go) begin
      act_reg  <= 1'b1;
      left_reg <= i_len;
    end else if (o_req && i_grant) begin
      act_reg  <= (left_reg != 4'h1);
      left_reg <= left_reg - 4'h1;
    end
  end
  assign o_req = act_reg & ~i_pause;
endmodule : mlpa_master_model

// ==== bench/mlpa_matrix_bench.sv ====
`timescale 1ns/1ps
// ============================================================
// Self-checking bench of the arbitration matrix
module mlpa_matrix_bench;
  import mlpa_pkg::*;
  logic              i_clock = 1'b0;
  logic              i_srst  = 1'b1;
  wire logic [19:0]  req;
  logic [19:0][1:0]  sel     = '0;
  logic [3:0]        wd      = 4'h0;
  logic [19:0]       grant, stall, loss;
  logic [3:0][4:0]   owner;
  logic [3:0]        busy;
  logic [19:0]       go      = '0;
  logic [19:0]       pause   = '0;
  logic [19:0][3:0]  len     = '0;
  int                miscompares = 0;
  int                samples_checked = 0;
  int                cycles = 0;

  always #5 i_clock = ~i_clock;

  mlpa_matrix dut (.i_clock(i_clock), .i_srst(i_srst), .i_req(req),
    .i_sel(sel), .i_word_done(wd), .o_grant(grant), .o_stall(stall),
    .o_owner(owner), .o_busy(busy), .o_unsafe_loss(loss));

  for (genvar m = 0; m < 20; m++) begin : g_m
    mlpa_master_model u_m (.i_clock(i_clock), .i_srst(i_srst),
      .i_go(go[m]), .i_pause(pause[m]), .i_grant(grant[m]),
      .i_len(len[m]), .o_req(req[m]));
  end

  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask : cyc
  task automatic check(input string nm, input logic [19:0] seen,
                       input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic rst();
    go = '0; pause = '0; wd = 4'h0; i_srst = 1'b1;
    cyc(2);
    i_srst = 1'b0;
  endtask : rst
  // Start master m on slave s, request seen after one edge
  task automatic start(input int m, input int s, input int l);
    sel[m] = s[1:0]; len[m] = l[3:0]; go[m] = 1'b1;
  endtask : start
  task automatic word();
    wd = 4'hF; cyc(1); wd = 4'h0;
  endtask : word

  // ==========================================================
  // Scenarios
  task automatic t_parallel();
    rst();
    check("busy", {16'h0000, busy}, 20'h00000);
    check("owner", owner, 20'h00000);
    // One master per slave
    start(5, 0, 9); start(9, 1, 9); cyc(1); go = '0; cyc(1);
    check("grant", grant, 20'h00220);
    check("owner", owner, 20'h00125);
    check("busy", {16'h0000, busy}, 20'h00003);
    $display("test parallel done");
  endtask : t_parallel
  task automatic t_ranking();
    for (int k = 0; k < 19; k++) begin
      rst(); start(k + 1, 2, 9); start(k, 2, 9); cyc(1); go = '0; cyc(1);
      check("grant", grant, 20'h1 << k);
      check("stall", stall, 20'h2 << k);
    end
    $display("test ranking done");
  endtask : t_ranking
  task automatic t_preempt();
    rst(); start(5, 0, 15); cyc(1); go = '0; cyc(1);
    start(0, 0, 3); cyc(1); go = '0; cyc(2);
    check("grant", grant, 20'h00020);
    word();
    check("grant", grant, 20'h00001);
    check("stall", stall, 20'h00020);
    for (int i = 0; i < 10 && grant !== 20'h00020; i++) cyc(1);
    check("grant", grant, 20'h00020);
    $display("test preempt done");
  endtask : t_preempt
  task automatic t_pause();
    rst(); start(0, 0, 15); start(5, 0, 15); cyc(1); go = '0; cyc(1);
    check("stall", stall, 20'h00020);
    pause[0] = 1'b1; cyc(1);
    check("grant", grant, 20'h00020);
    check("owner", owner, 20'h00005);
    pause[0] = 1'b0; cyc(1);
    check("stall", stall, 20'h00001);
    word();
    check("grant", grant, 20'h00001);
    $display("test pause done");
  endtask : t_pause
  task automatic t_unsafe();
    rst(); start(0, 3, 15); start(2, 3, 15); cyc(1); go = '0; cyc(2);
    check("loss", loss, 20'h00004);
    $display("test unsafe done");
  endtask : t_unsafe

  // ==========================================================
  // Verdict and watchdog
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  always @(posedge i_clock) begin
    cycles++;
    if (cycles >= 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    cyc(12);
    i_srst = 1'b0;
    cyc(1);
    t_parallel();
    t_ranking();
    t_preempt();
    t_pause();
    t_unsafe();
    print_verdict();
  end
endmodule : mlpa_matrix_bench
